// ===== verilog/rtc_alarm_and_timebase.sv
// Real-time clock core with alarm field enables, time-base selection and a Wishbone register slave.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
// What this block does
// R1: Alarm enable register resets to zero; top three bits always read zero.
// R2: Calendar mode: bit 4 includes the day-of-month comparison in the alarm.
// R3: Calendar mode: bit 3 includes the day-of-week comparison in the alarm.
// R4: Calendar mode: bit 2 includes the hours comparison in the alarm.
// R5: Calendar mode: bit 1 includes the minutes comparison in the alarm.
// R6: Calendar mode: bit 0 includes the seconds comparison in the alarm.
// R7: Counter mode: bits 4,2,1,0 gate byte lanes 0,1,2,3; bit 3 unused.
// R8: Software writes zero to reserved enable bits and timing bit 7.
// R9: Timing register resets to zero and is writable only while unlocked.
// R10: Rate choice 00 divides the source by 32768 for the tick.
// R11: Rate choice 01 is 60 Hz, 10 is 50 Hz, 11 uses prescale field.
// R12: Line rates set the divider so one count comes per second.
// R13: Prescale field divides by 1 to 128, used only with rate choice 11.
// R14: Source field picks 32 kHz clock, watch oscillator, system clock or event.
// R15: Control register resets to zero: unlocked, binary calendar, alarm clear.
// R16: Alarm flag updates only on lock being set or on a count increment.
// R17: Decimal enable makes counts and alarm set points count in BCD.
// R18: Locked: counts reject writes and run; unlocked: count stops, prescaler cleared.
// R19: Counter mode ignores decimal enable and counts plain binary.
// R20: Alarm is active when all enabled fields match; none enabled never alarms.
module rtc_alarm_and_timebase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic periph_32k_i,
  input wire logic watch_oscillator_i,
  input wire logic event_input_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic alarm_o,
  output logic tick_o
);
  logic [7:0] alarm_field_enables;
  rtc_pkg::timebase_s timebase_select;
  rtc_pkg::control_s control;
  rtc_pkg::lanes_s count_lanes;
  rtc_pkg::lanes_s alarm_lanes;
  logic [7:0] count_week_day;
  logic [7:0] alarm_week_day;
  logic [2:0] pin_raw;
  logic [2:0] pin_edge;
  logic source_edge;
  logic tick;
  logic alarm_match;
  logic reevaluate;
  logic bus_request;
  logic bus_write;
  logic [11:0] word_index;
  logic use_bcd;
  logic enables_write;
  logic timebase_write;
  logic control_write;
  logic lock_request;
  rtc_pkg::lanes_s next_count;
  logic [7:0] next_week_day;

  // Decodes a write to a byte-wide register that sits on lane 0 of the given word.
  function automatic logic byte_write(input logic write, input logic [11:0] index,
                                      input logic [3:0] sel, input logic [11:0] target);
    logic hit;
    hit = write && (index == target) && sel[0];
    return hit;
  endfunction : byte_write

  // Steps one field and reports whether it wrapped from its last value.
  function automatic logic [8:0] step_field(input logic [7:0] value, input logic [7:0] last,
                                            input logic [7:0] first, input logic bcd);
    logic [8:0] result;
    result = 9'h000;
    if (value >= last) begin
      result = {1'b1, first};
    end else if (bcd && value[3:0] >= 4'h9) begin
      result = {1'b0, value[7:4] + 4'h1, 4'h0};
    end else begin
      result = {1'b0, value + 8'h01};
    end
    return result;
  endfunction : step_field

  // Merges write data into an eight-bit register using the given byte lane.
  function automatic logic [7:0] lane_merge(input logic [7:0] old_value, input logic [31:0] data,
                                            input logic [3:0] sel, input int lane);
    logic [7:0] merged;
    merged = old_value;
    if (sel[lane]) begin
      merged = data[lane * 8 +: 8];
    end
    return merged;
  endfunction : lane_merge

  assign bus_request = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_request && wb_we_i;
  assign word_index = wb_adr_i[13:2];
  assign use_bcd = control.bcd_enable && !control.counter_mode; // [R17] [R19]
  assign enables_write = byte_write(bus_write, word_index, wb_sel_i, rtc_pkg::ALARM_FIELD_ENABLES_IDX);
  assign timebase_write = byte_write(bus_write, word_index, wb_sel_i, rtc_pkg::TIMEBASE_SELECT_IDX);
  assign control_write = byte_write(bus_write, word_index, wb_sel_i, rtc_pkg::CONTROL_IDX);
  assign lock_request = control_write && wb_dat_i[0] && !control.count_lock; // [R16]
  assign pin_raw = {event_input_i, watch_oscillator_i, periph_32k_i};

  // Each source pin crosses into this clock through two flip-flops; a third keeps the last level.
  for (genvar pin = 0; pin < 3; pin++) begin : g_pin_sync
    logic first_stage;
    logic second_stage;
    logic last_level;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        first_stage <= 1'b0;
        second_stage <= 1'b0;
        last_level <= 1'b0;
      end else begin
        first_stage <= pin_raw[pin];
        second_stage <= first_stage;
        last_level <= second_stage;
      end
    end

    assign pin_edge[pin] = second_stage && !last_level;
  end

  always_comb begin
    unique case (timebase_select.clock_source)
      rtc_pkg::SRC_PERIPH_32K: source_edge = pin_edge[0]; // [R14]
      rtc_pkg::SRC_WATCH_OSC: source_edge = pin_edge[1]; // [R14]
      rtc_pkg::SRC_SYSTEM_CLOCK: source_edge = 1'b1; // [R14]
      rtc_pkg::SRC_EVENT: source_edge = pin_edge[2]; // [R14]
    endcase
  end

  rtc_tick_divider divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(control.count_lock),
    .source_edge_i(source_edge),
    .timebase_i(timebase_select),
    .tick_o(tick)
  );

  rtc_alarm_match matcher (
    .count_i(count_lanes),
    .alarm_i(alarm_lanes),
    .count_week_day_i(count_week_day),
    .alarm_week_day_i(alarm_week_day),
    .enables_i(alarm_field_enables),
    .counter_mode_i(control.counter_mode),
    .match_o(alarm_match)
  );

  // Next count value for one tick in either mode.
  always_comb begin
    logic [8:0] sec_step;
    logic [8:0] min_step;
    logic [8:0] hour_step;
    logic [8:0] mday_step;
    logic [8:0] wday_step;
    sec_step = step_field(count_lanes.second,
                          use_bcd ? rtc_pkg::SECOND_LAST_BCD : rtc_pkg::SECOND_LAST_BIN, 8'h00, use_bcd);
    min_step = step_field(count_lanes.minute,
                          use_bcd ? rtc_pkg::SECOND_LAST_BCD : rtc_pkg::SECOND_LAST_BIN, 8'h00, use_bcd);
    hour_step = step_field(count_lanes.hour,
                           use_bcd ? rtc_pkg::HOUR_LAST_BCD : rtc_pkg::HOUR_LAST_BIN, 8'h00, use_bcd);
    mday_step = step_field(count_lanes.month_day,
                           use_bcd ? rtc_pkg::MONTH_DAY_LAST_BCD : rtc_pkg::MONTH_DAY_LAST_BIN,
                           rtc_pkg::DAY_FIRST, use_bcd);
    wday_step = step_field(count_week_day, rtc_pkg::WEEK_DAY_LAST, rtc_pkg::DAY_FIRST, 1'b0);
    next_count = count_lanes;
    next_week_day = count_week_day;
    if (control.counter_mode) begin
      next_count = count_lanes + 32'h0000_0001; // [R19]
    end else begin
      next_count.second = sec_step[7:0]; // [R17]
      if (sec_step[8]) begin
        next_count.minute = min_step[7:0];
        if (min_step[8]) begin
          next_count.hour = hour_step[7:0];
          if (hour_step[8]) begin
            next_count.month_day = mday_step[7:0];
            next_week_day = wday_step[7:0];
          end
        end
      end
    end
  end

  // Alarm field enables: top three bits are never stored and read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_field_enables <= rtc_pkg::ALARM_FIELD_ENABLES_RESET; // [R1]
    end else if (enables_write) begin
      alarm_field_enables <= {3'h0, wb_dat_i[rtc_pkg::ENABLE_WRITE_MASK_HI:0]}; // [R1] [R8]
    end
  end

  // Time-base selection is frozen while the count is locked.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timebase_select <= rtc_pkg::timebase_s'(rtc_pkg::TIMEBASE_SELECT_RESET); // [R9]
    end else if (timebase_write && !control.count_lock) begin
      timebase_select <= rtc_pkg::timebase_s'({1'b0, wb_dat_i[6:0]}); // [R9] [R8]
    end
  end

  // Control register: software bits, and the read-only sync flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= rtc_pkg::control_s'(rtc_pkg::CONTROL_RESET); // [R15]
    end else begin
      control.sync <= tick;
      if (control_write) begin
        control.spare_hi <= wb_dat_i[5];
        control.bcd_enable <= wb_dat_i[4];
        control.counter_mode <= wb_dat_i[3];
        control.spare_lo <= wb_dat_i[2];
        control.daylight_saving <= wb_dat_i[1];
        control.count_lock <= wb_dat_i[0];
      end
      if (reevaluate) begin
        control.alarm <= alarm_match; // [R16] [R20]
      end
    end
  end

  // The alarm is re-evaluated one cycle after a lock is set or the count steps.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reevaluate <= 1'b0;
    end else begin
      reevaluate <= tick || lock_request; // [R16]
    end
  end

  // Count lanes: writable only while unlocked, stepped by the tick while locked.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_lanes <= '0;
    end else if (control.count_lock) begin
      if (tick) begin
        count_lanes <= next_count; // [R18]
      end
    end else if (bus_write && word_index == rtc_pkg::COUNT_LANES_IDX) begin
      for (int lane = 0; lane < 4; lane++) begin
        count_lanes[lane * 8 +: 8] <= lane_merge(count_lanes[lane * 8 +: 8], wb_dat_i, wb_sel_i, lane); // [R18]
      end
    end
  end

  // Week-day count: follows the calendar carry while locked, writable while unlocked.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_week_day <= rtc_pkg::DAY_FIRST;
    end else if (control.count_lock) begin
      if (tick) begin
        count_week_day <= next_week_day; // [R18]
      end
    end else if (bus_write && word_index == rtc_pkg::WEEK_DAY_IDX) begin
      count_week_day <= lane_merge(count_week_day, wb_dat_i, wb_sel_i, 0); // [R18]
    end
  end

  // Alarm set points are always writable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_lanes <= '0;
    end else if (bus_write && word_index == rtc_pkg::ALARM_LANES_IDX) begin
      for (int lane = 0; lane < 4; lane++) begin
        alarm_lanes[lane * 8 +: 8] <= lane_merge(alarm_lanes[lane * 8 +: 8], wb_dat_i, wb_sel_i, lane);
      end
    end
  end

  // Week-day set point sits on lane 1 of the week-day word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_week_day <= 8'h00;
    end else if (bus_write && word_index == rtc_pkg::WEEK_DAY_IDX) begin
      alarm_week_day <= lane_merge(alarm_week_day, wb_dat_i, wb_sel_i, 1);
    end
  end

  // Wishbone answer: one wait state, acknowledge for every address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_request;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_request && !wb_we_i) begin
      unique case (word_index)
        rtc_pkg::ALARM_FIELD_ENABLES_IDX: wb_dat_o <= {24'h000000, alarm_field_enables}; // [R1]
        rtc_pkg::TIMEBASE_SELECT_IDX: wb_dat_o <= {24'h000000, timebase_select};
        rtc_pkg::CONTROL_IDX: wb_dat_o <= {24'h000000, control};
        rtc_pkg::COUNT_LANES_IDX: wb_dat_o <= count_lanes;
        rtc_pkg::ALARM_LANES_IDX: wb_dat_o <= alarm_lanes;
        rtc_pkg::WEEK_DAY_IDX: wb_dat_o <= {16'h0000, alarm_week_day, count_week_day};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      alarm_o <= (reevaluate) ? alarm_match : control.alarm;
      tick_o <= tick;
    end
  end
endmodule : rtc_alarm_and_timebase

// ===== verilog/rtc_pkg.sv
// Package with register map, field layouts, reset values and timing counts of the real-time clock block.
package rtc_pkg;
  localparam logic [11:0] ALARM_FIELD_ENABLES_IDX = 12'hF3C;
  localparam logic [11:0] TIMEBASE_SELECT_IDX = 12'hF3E;
  localparam logic [11:0] CONTROL_IDX = 12'hF3F;
  localparam logic [11:0] COUNT_LANES_IDX = 12'hF40;
  localparam logic [11:0] ALARM_LANES_IDX = 12'hF41;
  localparam logic [11:0] WEEK_DAY_IDX = 12'hF42;

  localparam logic [7:0] ALARM_FIELD_ENABLES_RESET = 8'h00;
  localparam logic [7:0] TIMEBASE_SELECT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int ENABLE_WRITE_MASK_HI = 4;
  localparam int SECOND_POS = 0;
  localparam int MINUTE_POS = 1;
  localparam int HOUR_POS = 2;
  localparam int WEEK_DAY_POS = 3;
  localparam int MONTH_DAY_POS = 4;

  localparam int SOURCE_RATE_HZ = 32768;
  localparam int LINE_60_HZ = 60;
  localparam int LINE_50_HZ = 50;
  localparam logic [14:0] DIV_32K_LAST = 15'(SOURCE_RATE_HZ - 1);
  localparam logic [14:0] DIV_60_LAST = 15'(LINE_60_HZ - 1);
  localparam logic [14:0] DIV_50_LAST = 15'(LINE_50_HZ - 1);

  localparam logic [7:0] SECOND_LAST_BIN = 8'h3B;
  localparam logic [7:0] SECOND_LAST_BCD = 8'h59;
  localparam logic [7:0] HOUR_LAST_BIN = 8'h17;
  localparam logic [7:0] HOUR_LAST_BCD = 8'h23;
  localparam logic [7:0] MONTH_DAY_LAST_BIN = 8'h1F;
  localparam logic [7:0] MONTH_DAY_LAST_BCD = 8'h31;
  localparam logic [7:0] WEEK_DAY_LAST = 8'h07;
  localparam logic [7:0] DAY_FIRST = 8'h01;

  typedef enum logic [1:0] {RATE_32K, RATE_60HZ, RATE_50HZ, RATE_PRESCALE} rate_e;
  typedef enum logic [1:0] {SRC_PERIPH_32K, SRC_WATCH_OSC, SRC_SYSTEM_CLOCK, SRC_EVENT} source_e;

  typedef struct packed {
    logic reserved;
    logic [2:0] prescale;
    rate_e source_rate_choice;
    source_e clock_source;
  } timebase_s;

  typedef struct packed {
    logic sync;
    logic alarm;
    logic spare_hi;
    logic bcd_enable;
    logic counter_mode;
    logic spare_lo;
    logic daylight_saving;
    logic count_lock;
  } control_s;

  typedef struct packed {
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] month_day;
  } lanes_s;
endpackage : rtc_pkg

// ===== verilog/rtc_tick_divider.sv
// Prescaler that turns source edges into one count tick per period.
`timescale 1ns/10ps
module rtc_tick_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic source_edge_i,
  input wire rtc_pkg::timebase_s timebase_i,
  output logic tick_o
);
  logic [14:0] div_count;
  logic [14:0] div_last;

  always_comb begin
    unique case (timebase_i.source_rate_choice)
      rtc_pkg::RATE_32K: div_last = rtc_pkg::DIV_32K_LAST; // [R10]
      rtc_pkg::RATE_60HZ: div_last = rtc_pkg::DIV_60_LAST; // [R11] [R12]
      rtc_pkg::RATE_50HZ: div_last = rtc_pkg::DIV_50_LAST; // [R11] [R12]
      rtc_pkg::RATE_PRESCALE: div_last = 15'((16'h0001 << timebase_i.prescale) - 16'h0001); // [R13]
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      div_count <= 15'h0000; // [R18]
    end else if (source_edge_i) begin
      div_count <= (div_count >= div_last) ? 15'h0000 : div_count + 15'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && source_edge_i && (div_count >= div_last);
    end
  end
endmodule : rtc_tick_divider

// ===== verilog/rtc_alarm_match.sv
// Comparison of count fields against alarm set points, gated by the field enables.
`timescale 1ns/10ps
module rtc_alarm_match (
  input wire rtc_pkg::lanes_s count_i,
  input wire rtc_pkg::lanes_s alarm_i,
  input wire logic [7:0] count_week_day_i,
  input wire logic [7:0] alarm_week_day_i,
  input wire logic [7:0] enables_i,
  input wire logic counter_mode_i,
  output logic match_o
);
  logic [4:0] field_equal;
  logic [4:0] field_used;

  always_comb begin
    field_equal[rtc_pkg::SECOND_POS] = count_i.second == alarm_i.second; // [R6] [R7]
    field_equal[rtc_pkg::MINUTE_POS] = count_i.minute == alarm_i.minute; // [R5] [R7]
    field_equal[rtc_pkg::HOUR_POS] = count_i.hour == alarm_i.hour; // [R4] [R7]
    field_equal[rtc_pkg::WEEK_DAY_POS] = count_week_day_i == alarm_week_day_i; // [R3]
    field_equal[rtc_pkg::MONTH_DAY_POS] = count_i.month_day == alarm_i.month_day; // [R2] [R7]
    field_used = enables_i[4:0];
    if (counter_mode_i) begin
      field_used[rtc_pkg::WEEK_DAY_POS] = 1'b0; // [R7]
    end
    match_o = (field_used != 5'h00) && ((field_equal | ~field_used) == 5'h1F); // [R20]
  end
endmodule : rtc_alarm_match

// ===== verif/rtc_alarm_and_timebase_sva.sv
// Checker of the register slave, tick and alarm outputs of the real-time clock block.
`timescale 1ns/10ps
module rtc_alarm_and_timebase_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic alarm_o,
  input wire logic tick_o
);
  logic wr;
  logic [2:0] idle_cnt;
  logic [4:0] en;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Counts cycles since the count was unlocked, saturating at seven.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt <= 3'h1;
    end else if (wr && wb_adr_i[13:2] == rtc_pkg::CONTROL_IDX) begin
      idle_cnt <= wb_dat_i[0] ? 3'h0 : 3'h1;
    end else if (idle_cnt != 3'h0 && idle_cnt != 3'h7) begin
      idle_cnt <= idle_cnt + 3'h1;
    end
  end
  // Tracks the alarm field enables last written.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en <= 5'h00;
    end else if (wr && wb_adr_i[13:2] == rtc_pkg::ALARM_FIELD_ENABLES_IDX) begin
      en <= wb_dat_i[4:0];
    end
  end
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !alarm_o && !tick_o)
    else $error("outputs active after reset");
  a_alarm_cause: assert property ($changed(alarm_o) |-> $past(tick_o) ||
    $past(wr && wb_adr_i[13:2] == rtc_pkg::CONTROL_IDX && wb_dat_i[0]))
    else $error("alarm changed without tick or lock");
  a_no_tick_unlocked: assert property (idle_cnt == 3'h7 |-> !tick_o)
    else $error("tick while unlocked");
  a_enable_top_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[13:2] == rtc_pkg::ALARM_FIELD_ENABLES_IDX |-> wb_dat_o[7:5] == 3'h0)
    else $error("enable top bits not zero");
  a_timebase_top_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[13:2] == rtc_pkg::TIMEBASE_SELECT_IDX |-> !wb_dat_o[7])
    else $error("timebase top bit not zero");
  a_alarm_needs_enable: assert property ($rose(alarm_o) |-> en != 5'h00)
    else $error("alarm with no field enabled");
  c_alarm: cover property ($rose(alarm_o));
  c_tick: cover property (tick_o);
  c_timebase_write: cover property (wr && wb_adr_i[13:2] == rtc_pkg::TIMEBASE_SELECT_IDX);
endmodule : rtc_alarm_and_timebase_sva
bind rtc_alarm_and_timebase rtc_alarm_and_timebase_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .alarm_o(alarm_o), .tick_o(tick_o));

// ===== verif/tb_top.sv
// Self-checking testbench of the real-time clock alarm and time-base block.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic periph_32k_i = 1'b0;
  logic watch_oscillator_i = 1'b0;
  logic event_input_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic alarm_o;
  logic tick_o;
  logic [7:0] phase = 8'h00;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;
  rtc_alarm_and_timebase dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .periph_32k_i(periph_32k_i), .watch_oscillator_i(watch_oscillator_i), .event_input_i(event_input_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_o(alarm_o), .tick_o(tick_o));
  always #2.5 clk_i = ~clk_i;
  // Source pins toggle with periods of 8, 32 and 16 clocks.
  always @(posedge clk_i) begin
    phase <= phase + 8'h01;
    periph_32k_i <= phase[2];
    watch_oscillator_i <= phase[4];
    event_input_i <= phase[3];
  end
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic xfer(input logic we, input logic [11:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) begin
      fail_count++;
      $display("BAD ack expected 1 seen 0");
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic regs_check();
    xfer(1'b0, rtc_pkg::ALARM_FIELD_ENABLES_IDX, 32'h0);
    check("enables", 32'h0, rd);
    xfer(1'b0, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h0);
    check("timebase", 32'h0, rd);
    xfer(1'b0, rtc_pkg::CONTROL_IDX, 32'h0);
    check("control", 32'h0, rd);
    xfer(1'b1, rtc_pkg::ALARM_FIELD_ENABLES_IDX, 32'h1F);
    xfer(1'b0, rtc_pkg::ALARM_FIELD_ENABLES_IDX, 32'h0);
    check("enables", 32'h1F, rd);
    xfer(1'b1, 12'h000, 32'hFF);
    xfer(1'b0, 12'h000, 32'h0);
    check("unmapped", 32'h0, rd);
    xfer(1'b1, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h7E);
    xfer(1'b1, rtc_pkg::CONTROL_IDX, 32'h1);
    xfer(1'b1, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h0);
    xfer(1'b0, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h0);
    check("timebase locked", 32'h7E, rd);
  endtask : regs_check
  task automatic tick_rate(input logic [7:0] tb, input int per, input int n);
    int c;
    int w;
    c = 0;
    w = 0;
    xfer(1'b1, rtc_pkg::CONTROL_IDX, 32'h0);
    xfer(1'b1, rtc_pkg::TIMEBASE_SELECT_IDX, {24'h0, tb});
    xfer(1'b1, rtc_pkg::CONTROL_IDX, 32'h1);
    while (tick_o !== 1'b1 && w < per + 40) begin
      @(posedge clk_i);
      w++;
    end
    repeat (per * n) begin
      @(posedge clk_i);
      if (tick_o === 1'b1) begin
        c++;
      end
    end
    check("ticks", n, c);
  endtask : tick_rate
  task automatic unlocked_idle();
    int c;
    c = 0;
    xfer(1'b1, rtc_pkg::CONTROL_IDX, 32'h0);
    repeat (300) begin
      @(posedge clk_i);
      if (tick_o !== 1'b0) begin
        c++;
      end
    end
    check("unlocked ticks", 32'h0, c);
  endtask : unlocked_idle
  task automatic bcd_step(input logic [7:0] mode, input logic [31:0] start, input logic [31:0] exp);
    int w;
    w = 0;
    xfer(1'b1, rtc_pkg::CONTROL_IDX, {24'h0, mode});
    xfer(1'b1, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h7E);
    xfer(1'b1, rtc_pkg::COUNT_LANES_IDX, start);
    xfer(1'b1, rtc_pkg::CONTROL_IDX, {24'h0, mode | 8'h01});
    while (tick_o !== 1'b1 && w < 300) begin
      @(posedge clk_i);
      w++;
    end
    xfer(1'b0, rtc_pkg::COUNT_LANES_IDX, 32'h0);
    check("stepped count", exp, rd);
  endtask : bcd_step
  task automatic run_alarm(input logic [7:0] mode, input logic [7:0] en, input logic [31:0] lanes,
                           input logic hit, input logic [31:0] cnt);
    int w;
    logic seen;
    w = 0;
    seen = 1'b0;
    xfer(1'b1, rtc_pkg::CONTROL_IDX, {24'h0, mode});
    xfer(1'b1, rtc_pkg::TIMEBASE_SELECT_IDX, 32'h7E);
    xfer(1'b1, rtc_pkg::COUNT_LANES_IDX, 32'h0);
    xfer(1'b1, rtc_pkg::WEEK_DAY_IDX, 32'h0101);
    xfer(1'b1, rtc_pkg::ALARM_LANES_IDX, lanes);
    xfer(1'b1, rtc_pkg::ALARM_FIELD_ENABLES_IDX, {24'h0, en});
    xfer(1'b1, rtc_pkg::CONTROL_IDX, {24'h0, mode | 8'h01});
    while (w < 1000 && !seen) begin
      @(posedge clk_i);
      seen = (alarm_o === 1'b1);
      w++;
    end
    check("alarm", {31'h0, hit}, {31'h0, seen});
    if (hit) begin
      xfer(1'b0, rtc_pkg::COUNT_LANES_IDX, 32'h0);
      check("count", cnt, rd);
    end
  endtask : run_alarm
  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    regs_check();
    tick_rate(8'h1E, 2, 10);
    tick_rate(8'h7E, 128, 4);
    tick_rate(8'h06, 60, 4);
    tick_rate(8'h0A, 50, 4);
    tick_rate(8'h02, 32768, 1);
    tick_rate(8'h0C, 8, 4);
    tick_rate(8'h0D, 32, 4);
    tick_rate(8'h0F, 16, 4);
    unlocked_idle();
    bcd_step(8'h10, 32'h59090000, 32'h00100000);
    bcd_step(8'h18, 32'h00000009, 32'h0000000A);
    run_alarm(8'h00, 8'h01, 32'h03000000, 1'b1, 32'h03000000);
    run_alarm(8'h00, 8'h02, 32'h05000505, 1'b1, 32'h0);
    run_alarm(8'h00, 8'h04, 32'h05050005, 1'b1, 32'h0);
    run_alarm(8'h00, 8'h08, 32'h05050505, 1'b1, 32'h0);
    run_alarm(8'h00, 8'h10, 32'h05050500, 1'b1, 32'h0);
    run_alarm(8'h08, 8'h10, 32'h00000003, 1'b1, 32'h00000003);
    run_alarm(8'h08, 8'h04, 32'h0000FF00, 1'b0, 32'h0);
    run_alarm(8'h00, 8'h00, 32'h0, 1'b0, 32'h0);
    end_of_test();
  end
endmodule : tb_top
